// *** hw/brwcr_pkg.sv ***
// brwcr_pkg: offsets, field positions, reset values, timing and state codes
// for the self-test status, reset control and wake-up control registers.
// assumes a 16-bit host register port with byte addresses and byte enables.
package brwcr_pkg;

    // register port geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h124;
    localparam logic [ADDR_W-1:0] GCTRL_OFS = 12'h126;
    localparam logic [ADDR_W-1:0] WAKE_OFS = 12'h12a;

    // memory_selftest_status fields
    localparam int ST_DONE_BIT = 15;
    localparam int ST_TX_CMP_BIT = 12;
    localparam int ST_TX_FAIL_BIT = 11;
    localparam int ST_TX_CNT_LSB = 8;
    localparam int ST_RX_CMP_BIT = 4;
    localparam int ST_RX_FAIL_BIT = 3;
    localparam int ST_RX_CNT_LSB = 0;
    localparam int FAIL_CNT_W = 3;

    // global_reset_control fields
    localparam int GC_BIST_START_BIT = 3;
    localparam int GC_QM_RESET_BIT = 1;
    localparam int GC_SOFT_RESET_BIT = 0;
    localparam logic [DATA_W-1:0] GCTRL_RST = 16'h0000;

    // wakeup_frame_control fields
    localparam int WF_MAGIC_BIT = 7;
    localparam int WF_PAT_LSB = 0;
    localparam int WF_PAT_N = 4;
    localparam logic WF_MAGIC_RST = 1'b0;
    localparam logic [WF_PAT_N-1:0] WF_PAT_RST = 4'h0;

    // byte lanes
    localparam int LANE_W = 8;
    localparam int LANE_LO = 0;
    localparam int LANE_HI = 1;

    // soft reset hold time
    localparam int SOFT_RST_HOLD_MS = 10;
    localparam int CLK_KHZ = 250000;
    localparam int SOFT_RST_HOLD_CYC = SOFT_RST_HOLD_MS * CLK_KHZ;

    // self-test tracker
    typedef enum logic [2:0] {
        BRWCR_ST_RUN = 3'b001,
        BRWCR_ST_DONE = 3'b010,
        BRWCR_ST_HALT = 3'b100
    } brwcr_st_e;

endpackage

// *** hw/brwcr_capture.sv ***
// brwcr_capture: holds the outcome of one packet memory self-test.
// assumes the test engine pulses done for one cycle with fail and count valid.
`timescale 1ns/1ps
`default_nettype none

module brwcr_capture
    import brwcr_pkg::*;
#(
    parameter int CNT_W = FAIL_CNT_W
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // control
    input wire logic clear,
    // test engine result
    input wire logic done,
    input wire logic fail,
    input wire logic [CNT_W-1:0] fail_count,
    // held result
    output logic complete_q,
    output logic failed_q,
    output logic [CNT_W-1:0] count_q
);

    // a result landing in the clearing cycle is kept: set wins over clear
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            complete_q <= 1'b0;
            failed_q <= 1'b0;
            count_q <= '0;
        end
        else if (done)
        begin
            complete_q <= 1'b1;
            failed_q <= fail;
            count_q <= fail_count;
        end
        else if (clear)
        begin
            complete_q <= 1'b0;
            failed_q <= 1'b0;
            count_q <= '0;
        end
    end

endmodule

`default_nettype wire

// *** hw/brwcr_regs.sv ***
// brwcr_regs: self-test status, global/queue reset control and wake-up enables.
// assumes a synchronous host register port; the test engine, queue manager
// and wake-up detectors sit outside and follow the levels driven here.
//
// Functional notes
// - Both memory self-test outcomes are readable in a read-only status register.
// - Status bit 15 reads 0 while the self-test runs and 1 once both tests completed without a stop.
// - Status bit 12 reads 1 once the transmit memory test completed.
// - Status bit 11 reads 1 when the transmit memory test completed with a failure.
// - Status bits 10:8 are nonzero when the transmit test saw a failed count.
// - Status bit 4 reads 1 once the receive memory test completed.
// - Status bit 3 reads 1 when the receive memory test failed.
// - Status bits 2:0 are nonzero when the receive test saw a failed count.
// - Reset control bit 3 written 1 starts the self-test and written 0 stops it.
// - While reset control bit 1 is set the queue manager is flushed and reset.
// - While reset control bit 0 is set all registers return to default.
// - The global soft reset bit never clears itself; software holds it 10 ms.
// - Wake-up control bit 7 enables magic-packet detection.
// - Wake-up control bits 3:0 enable wake-up frame patterns 0 to 3.
`timescale 1ns/1ps
`default_nettype none

module brwcr_regs
    import brwcr_pkg::*;
#(
    parameter int HOLD_CYC = SOFT_RST_HOLD_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // host register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [1:0] reg_be,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    // memory self-test engine
    input wire logic tx_test_done,
    input wire logic tx_test_fail,
    input wire logic [FAIL_CNT_W-1:0] tx_test_fail_count,
    input wire logic rx_test_done,
    input wire logic rx_test_fail,
    input wire logic [FAIL_CNT_W-1:0] rx_test_fail_count,
    output logic bist_run,
    // reset controls
    output logic queue_manager_flush,
    output logic global_soft_reset,
    output logic soft_reset_hold_met,
    // wake-up detection enables
    output logic magic_packet_detect_enable,
    output logic wake_pattern0_enable,
    output logic wake_pattern1_enable,
    output logic wake_pattern2_enable,
    output logic wake_pattern3_enable
);

    localparam int HOLD_W = $clog2(HOLD_CYC + 1);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC);

    logic [DATA_W-1:0] gctrl_q;
    logic [DATA_W-1:0] gctrl_d;
    logic magic_q;
    logic [WF_PAT_N-1:0] pat_q;
    logic [DATA_W-1:0] rdata_q;
    logic [HOLD_W-1:0] hold_cnt_q;
    logic hold_met_q;
    brwcr_st_e state_q;
    brwcr_st_e state_d;

    logic tx_cmp;
    logic tx_failed;
    logic [FAIL_CNT_W-1:0] tx_cnt;
    logic rx_cmp;
    logic rx_failed;
    logic [FAIL_CNT_W-1:0] rx_cnt;

    // byte-lane merge of a write into a stored word
    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] wdata,
        input logic [1:0] be
    );
        logic [DATA_W-1:0] res;
        res = old;
        if (be[LANE_LO])
            res[LANE_W-1:0] = wdata[LANE_W-1:0];
        if (be[LANE_HI])
            res[DATA_W-1:LANE_W] = wdata[DATA_W-1:LANE_W];
        return res;
    endfunction

    // address decode
    wire sel_status = (reg_addr == STATUS_OFS);
    wire sel_gctrl = (reg_addr == GCTRL_OFS);
    wire sel_wake = (reg_addr == WAKE_OFS);
    wire wr_gctrl = reg_wr && sel_gctrl;
    wire wr_wake_lo = reg_wr && sel_wake && reg_be[LANE_LO];
    wire gsr = gctrl_q[GC_SOFT_RESET_BIT];

    // while the soft reset is held only its own bit stays writable, so software
    // can release it; everything else is forced to default
    wire [DATA_W-1:0] gctrl_wr = merge(gctrl_q, reg_wdata, reg_be);
    always_comb
    begin
        gctrl_d = gctrl_q;
        if (wr_gctrl)
            gctrl_d = gctrl_wr;
        if (gsr)
        begin
            gctrl_d = GCTRL_RST;
            gctrl_d[GC_SOFT_RESET_BIT] = wr_gctrl ? gctrl_wr[GC_SOFT_RESET_BIT] : 1'b1;
        end
    end

    wire start_new = gctrl_d[GC_BIST_START_BIT] && !gctrl_q[GC_BIST_START_BIT];
    wire stop_req = !gctrl_d[GC_BIST_START_BIT] && gctrl_q[GC_BIST_START_BIT];
    wire cap_clear = gsr || start_new;
    wire both_cmp = tx_cmp && rx_cmp;

    // self-test tracker: a fresh start wins over completion and stop
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            BRWCR_ST_RUN:
            begin
                if (stop_req)
                    state_d = BRWCR_ST_HALT;
                else if (both_cmp && !cap_clear)
                    state_d = BRWCR_ST_DONE;
            end
            BRWCR_ST_DONE, BRWCR_ST_HALT:
                state_d = state_q;
        endcase
        if (cap_clear)
            state_d = BRWCR_ST_RUN;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gctrl_q <= GCTRL_RST;
            state_q <= BRWCR_ST_RUN;
        end
        else
        begin
            gctrl_q <= gctrl_d;
            state_q <= state_d;
        end
    end

    // wake-up enables; writes are ignored while the global soft reset is held
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            magic_q <= WF_MAGIC_RST;
            pat_q <= WF_PAT_RST;
        end
        else if (gsr)
        begin
            magic_q <= WF_MAGIC_RST;
            pat_q <= WF_PAT_RST;
        end
        else if (wr_wake_lo)
        begin
            magic_q <= reg_wdata[WF_MAGIC_BIT];
            pat_q <= reg_wdata[WF_PAT_LSB +: WF_PAT_N];
        end
    end

    // counts how long the soft reset has been held; the flag tells software
    // the hold time has passed without it having to keep its own timer
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hold_cnt_q <= '0;
            hold_met_q <= 1'b0;
        end
        else if (!gsr)
        begin
            hold_cnt_q <= '0;
            hold_met_q <= 1'b0;
        end
        else if (hold_cnt_q != HOLD_LAST)
        begin
            hold_cnt_q <= hold_cnt_q + HOLD_W'(1);
            hold_met_q <= 1'b0;
        end
        else
        begin
            hold_met_q <= 1'b1;
        end
    end

    // per-memory result holders
    brwcr_capture #(.CNT_W(FAIL_CNT_W)) u_tx_cap (
        .clk(clk), .resetn(resetn), .clear(cap_clear),
        .done(tx_test_done), .fail(tx_test_fail), .fail_count(tx_test_fail_count),
        .complete_q(tx_cmp), .failed_q(tx_failed), .count_q(tx_cnt)
    );

    brwcr_capture #(.CNT_W(FAIL_CNT_W)) u_rx_cap (
        .clk(clk), .resetn(resetn), .clear(cap_clear),
        .done(rx_test_done), .fail(rx_test_fail), .fail_count(rx_test_fail_count),
        .complete_q(rx_cmp), .failed_q(rx_failed), .count_q(rx_cnt)
    );

    // status word; reserved bits read 0
    logic [DATA_W-1:0] status_w;
    always_comb
    begin
        status_w = '0;
        status_w[ST_DONE_BIT] = (state_q == BRWCR_ST_DONE);
        status_w[ST_TX_CMP_BIT] = tx_cmp;
        status_w[ST_TX_FAIL_BIT] = tx_failed;
        status_w[ST_TX_CNT_LSB +: FAIL_CNT_W] = tx_cnt;
        status_w[ST_RX_CMP_BIT] = rx_cmp;
        status_w[ST_RX_FAIL_BIT] = rx_failed;
        status_w[ST_RX_CNT_LSB +: FAIL_CNT_W] = rx_cnt;
    end

    logic [DATA_W-1:0] wake_w;
    always_comb
    begin
        wake_w = '0;
        wake_w[WF_MAGIC_BIT] = magic_q;
        wake_w[WF_PAT_LSB +: WF_PAT_N] = pat_q;
    end

    // unmapped offsets read 0; read data held until the next read
    wire [DATA_W-1:0] rd_mux = sel_status ? status_w :
                               sel_gctrl ? gctrl_q :
                               sel_wake ? wake_w : '0;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata_q <= '0;
        else if (reg_rd)
            rdata_q <= rd_mux;
    end

    assign reg_rdata = rdata_q;
    assign bist_run = state_q[0];
    assign queue_manager_flush = gctrl_q[GC_QM_RESET_BIT];
    assign global_soft_reset = gsr;
    assign soft_reset_hold_met = hold_met_q;
    assign magic_packet_detect_enable = magic_q;
    assign wake_pattern0_enable = pat_q[0];
    assign wake_pattern1_enable = pat_q[1];
    assign wake_pattern2_enable = pat_q[2];
    assign wake_pattern3_enable = pat_q[3];

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_status_read;
        reg_rd && sel_status |=> reg_rdata == $past(status_w);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_done_set;
        state_q == BRWCR_ST_RUN && both_cmp && !cap_clear && !stop_req
            |=> status_w[ST_DONE_BIT] && !bist_run;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done bit not set");

    property p_tx_cmp;
        tx_test_done |=> tx_cmp && tx_failed == $past(tx_test_fail);
    endproperty
    a_tx_cmp: assert property (p_tx_cmp) else $error("tx result not held");

    property p_tx_cnt;
        tx_test_done |=> tx_cnt == $past(tx_test_fail_count);
    endproperty
    a_tx_cnt: assert property (p_tx_cnt) else $error("tx count not held");

    property p_rx_cmp;
        rx_test_done |=> rx_cmp && rx_failed == $past(rx_test_fail);
    endproperty
    a_rx_cmp: assert property (p_rx_cmp) else $error("rx result not held");

    property p_rx_cnt;
        rx_test_done |=> rx_cnt == $past(rx_test_fail_count);
    endproperty
    a_rx_cnt: assert property (p_rx_cnt) else $error("rx count not held");

    property p_start;
        wr_gctrl && reg_be[LANE_LO] && !gsr && reg_wdata[GC_BIST_START_BIT]
            && !gctrl_q[GC_BIST_START_BIT] |=> bist_run && !tx_cmp && !rx_cmp;
    endproperty
    a_start: assert property (p_start) else $error("start did not run test");

    property p_flush;
        wr_gctrl && reg_be[LANE_LO] && !gsr && reg_wdata[GC_QM_RESET_BIT]
            |=> queue_manager_flush ##1 queue_manager_flush || wr_gctrl;
    endproperty
    a_flush: assert property (p_flush) else $error("flush not held");

    property p_gsr_clear;
        gsr |=> !magic_packet_detect_enable && !queue_manager_flush && bist_run;
    endproperty
    a_gsr_clear: assert property (p_gsr_clear) else $error("soft reset left state");

    property p_gsr_sticky;
        gsr && !wr_gctrl |=> gsr;
    endproperty
    a_gsr_sticky: assert property (p_gsr_sticky) else $error("soft reset cleared itself");

    property p_wake_en;
        wr_wake_lo && !gsr |=> magic_packet_detect_enable == $past(reg_wdata[WF_MAGIC_BIT])
            && wake_pattern3_enable == $past(reg_wdata[3]) && wake_pattern0_enable == $past(reg_wdata[0]);
    endproperty
    a_wake_en: assert property (p_wake_en) else $error("wake enable not written");

    property p_result_stable;
        tx_cmp && !tx_test_done && !cap_clear |=> $stable(tx_failed) && $stable(tx_cnt);
    endproperty
    a_result_stable: assert property (p_result_stable) else $error("result changed");

    c_test_done: cover property (state_q == BRWCR_ST_RUN ##1 state_q == BRWCR_ST_DONE);
    c_soft_reset: cover property (gsr ##1 !gsr);
    c_magic_on: cover property ($rose(magic_packet_detect_enable));

endmodule

`default_nettype wire

// *** test/brwcr_regs_tb.sv ***
// brwcr_regs_tb: self-checking bench for the self-test, reset and wake-up registers.
// assumes the host port timing of the design; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none

module brwcr_regs_tb
    import brwcr_pkg::*;
;
    localparam int HOLD = 20;
    typedef struct {
        logic [ADDR_W-1:0] addr;
        logic [1:0] be;
        logic [DATA_W-1:0] wd;
        logic [DATA_W-1:0] rd;
    } brwcr_row_s;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] reg_be = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic txd = 1'b0;
    logic txf = 1'b0;
    logic [2:0] txc = '0;
    logic rxd = 1'b0;
    logic rxf = 1'b0;
    logic [2:0] rxc = '0;
    logic bist_run, qm_flush, gsr, hold_met, mp_en, p0, p1, p2, p3;
    logic [DATA_W-1:0] rv;
    logic [DATA_W-1:0] exp_wf;
    logic [DATA_W-1:0] exp_gc;
    int fail_count = 0;
    int tests_run = 0;

    brwcr_row_s rows [9] = '{
        '{WAKE_OFS, 2'b01, 16'h00ff, 16'h008f},
        '{WAKE_OFS, 2'b11, 16'hff70, 16'h0000},
        '{WAKE_OFS, 2'b11, 16'h0081, 16'h0081},
        '{WAKE_OFS, 2'b10, 16'h0000, 16'h0081},
        '{GCTRL_OFS, 2'b11, 16'hfff4, 16'hfff4},
        '{GCTRL_OFS, 2'b01, 16'h0002, 16'hff02},
        '{GCTRL_OFS, 2'b11, 16'h0000, 16'h0000},
        '{STATUS_OFS, 2'b11, 16'hffff, 16'h0000},
        '{12'h128, 2'b11, 16'hffff, 16'h0000}
    };

    always #2 clk = ~clk;

    brwcr_regs #(.HOLD_CYC(HOLD)) i_dut (
        .clk(clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .tx_test_done(txd), .tx_test_fail(txf), .tx_test_fail_count(txc),
        .rx_test_done(rxd), .rx_test_fail(rxf), .rx_test_fail_count(rxc),
        .bist_run(bist_run), .queue_manager_flush(qm_flush), .global_soft_reset(gsr),
        .soft_reset_hold_met(hold_met), .magic_packet_detect_enable(mp_en),
        .wake_pattern0_enable(p0), .wake_pattern1_enable(p1),
        .wake_pattern2_enable(p2), .wake_pattern3_enable(p3)
    );

    task automatic chk16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t flag got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [1:0] be,
                      input logic [DATA_W-1:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_be = be;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic pulse(input logic is_tx, input logic f, input logic [2:0] c);
        @(negedge clk);
        if (is_tx)
        begin
            txd = 1'b1;
            txf = f;
            txc = c;
        end
        else
        begin
            rxd = 1'b1;
            rxf = f;
            rxc = c;
        end
        @(negedge clk);
        txd = 1'b0;
        rxd = 1'b0;
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        end_sim();
    end

    initial
    begin
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        // reset state: power-up test running, everything else cleared
        chk1(bist_run, 1'b1);
        rd(STATUS_OFS, rv);
        chk16(rv, 16'h0000);
        $display("test reset state done");
        exp_wf = '0;
        exp_gc = '0;
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].be, rows[i].wd);
            rd(rows[i].addr, rv);
            chk16(rv, rows[i].rd);
            if (rows[i].addr == WAKE_OFS)
                exp_wf = rows[i].rd;
            if (rows[i].addr == GCTRL_OFS)
                exp_gc = rows[i].rd;
            chk16({9'h0, mp_en, p3, p2, p1, p0, qm_flush, gsr},
                  {9'h0, exp_wf[7], exp_wf[3:0], exp_gc[1:0]});
        end
        $display("test register table done");

        pulse(1'b1, 1'b1, 3'h5);
        rd(STATUS_OFS, rv);
        chk16(rv, 16'h1d00);
        pulse(1'b0, 1'b0, 3'h0);
        repeat (2) @(negedge clk);
        rd(STATUS_OFS, rv);
        chk16(rv, 16'h9d10);
        chk1(bist_run, 1'b0);
        repeat (5) @(negedge clk);
        rd(STATUS_OFS, rv);
        chk16(rv, 16'h9d10);
        $display("test self-test completion done");

        wr(GCTRL_OFS, 2'b11, 16'h0008);
        chk1(bist_run, 1'b1);
        rd(STATUS_OFS, rv);
        chk16(rv, 16'h0000);
        wr(GCTRL_OFS, 2'b11, 16'h0000);
        chk1(bist_run, 1'b0);
        pulse(1'b1, 1'b0, 3'h0);
        pulse(1'b0, 1'b1, 3'h7);
        repeat (3) @(negedge clk);
        rd(STATUS_OFS, rv);
        chk16(rv, 16'h101f);
        $display("test self-test stop done");

        wr(WAKE_OFS, 2'b11, 16'h008f);
        wr(GCTRL_OFS, 2'b11, 16'h000a);
        wr(GCTRL_OFS, 2'b11, 16'h0001);
        chk1(hold_met, 1'b0);
        rd(GCTRL_OFS, rv);
        chk16(rv, 16'h0001);
        wr(WAKE_OFS, 2'b11, 16'h0081);
        rd(WAKE_OFS, rv);
        chk16(rv, 16'h0000);
        // soft reset forces the tracker back to run and clears flush and wake enables
        chk16({10'h0, mp_en, p0, qm_flush, gsr, bist_run, 1'b0},
              16'h0006);
        rd(STATUS_OFS, rv);
        chk16(rv, 16'h0000);
        repeat (HOLD + 2) @(negedge clk);
        chk1(hold_met, 1'b1);
        chk1(gsr, 1'b1);
        wr(GCTRL_OFS, 2'b11, 16'h0000);
        repeat (2) @(negedge clk);
        chk1(gsr, 1'b0);
        chk1(hold_met, 1'b0);
        wr(WAKE_OFS, 2'b01, 16'h0001);
        chk1(p0, 1'b1);
        $display("test soft reset done");

        // device reset while the test still runs, after only a failed transmit result
        pulse(1'b1, 1'b1, 3'h1);
        @(negedge clk);
        resetn = 1'b0;
        #1;
        chk16({reg_rdata[14:0], bist_run}, 16'h0001);
        chk1(p0, 1'b0);
        @(negedge clk);
        resetn = 1'b1;
        rd(STATUS_OFS, rv);
        chk16(rv, 16'h0000);
        $display("test async reset done");
        end_sim();
    end
endmodule

`default_nettype wire
